// file: verilog/adcsq_params.svh
// Constants for the converter sequencer control block: offsets, fields,
// reset values and conversion lengths.
// Assumes a plain register port with byte-wide registers at printed offsets.
//
// Contract
// - Mode 01: start bit launches one conversion
// - Mode 11: each completion restarts same channel
// - Mode 00 aborts at once, no result stored
// - Completion loads result, sets end flag, interrupts
// - Start bit self-clears once conversion begins
// - Channel field bits 3..0, codes 0..7 valid
// - Input gate bit 4: 0 enables, 1 disables
// - Standby resets controls and blocks their writes
// - Control two bits 7..6 read undefined
// - Time code selects 39..1248 oscillator cycles
// - Status: result bits 7..6, end 5, busy 4
// - Reading result upper clears end flag
// - Busy set at start, cleared at finish (kept set in mode 11) or standby
// - Restart clears end flag, old result kept
// - Ten-bit successive approximation result per conversion
// - Result upper holds latest completed conversion
// - No automatic restart after standby
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH
`define ADCSQ_OFS_CTRL1 8'h1c
`define ADCSQ_OFS_CTRL2 8'h1d
`define ADCSQ_OFS_RESU 8'h1f
`define ADCSQ_OFS_STAT 8'h1e
`define ADCSQ_RST_CTRL1 8'h10
`define ADCSQ_RST_CTRL2 8'h10
`define ADCSQ_MODE_OFF 2'h0
`define ADCSQ_MODE_SINGLE 2'h1
`define ADCSQ_MODE_REPEAT 2'h3
`define ADCSQ_BIT_START 7
`define ADCSQ_BIT_GATE 4
`define ADCSQ_CYC_000 11'd39
`define ADCSQ_CYC_010 11'd78
`define ADCSQ_CYC_011 11'd156
`define ADCSQ_CYC_100 11'd312
`define ADCSQ_CYC_101 11'd624
`define ADCSQ_CYC_110 11'd1248
`endif

// file: verilog/adcsq_pkg.sv
// Types shared by the converter sequencer control block.
// Assumes the constants header is included alongside.
package adcsq_pkg;
   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ADCSQ_IDLE = 2'b01,
      ADCSQ_CONV = 2'b10
   } adcsq_state_t;
   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } adcsq_req_t;
endpackage

// file: verilog/adcsq_top.sv
// Sequencer control for the 10-bit converter: registers, timing, results.
// Assumes the analog front end presents a settled 10-bit code by completion.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_params.svh"
module adcsq_top
   import adcsq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire adcsq_req_t req,
   output logic [7:0] rdata,
   input wire logic standby,
   input wire logic [9:0] afe_code,
   output logic [2:0] afe_channel,
   output logic afe_gate_off,
   output logic afe_sample,
   output logic ladder_connect,
   output logic conv_done_irq
);
   // Control and status storage
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] res_upper_reg;
   logic [1:0] res_low_reg;
   logic conv_end_flag_reg;
   logic conv_busy_flag_reg;
   logic [10:0] cnt_reg;
   logic [10:0] len_reg;
   adcsq_state_t state_reg;
   logic [7:0] rdata_reg;
   logic irq_reg;
   logic sample_reg;

   // Length lookup; reserved codes fall back to the longest length
   function automatic logic [10:0] conv_len(input logic [2:0] code);
      case (code)
         3'h0: conv_len = `ADCSQ_CYC_000;
         3'h2: conv_len = `ADCSQ_CYC_010;
         3'h3: conv_len = `ADCSQ_CYC_011;
         3'h4: conv_len = `ADCSQ_CYC_100;
         3'h5: conv_len = `ADCSQ_CYC_101;
         default: conv_len = `ADCSQ_CYC_110;
      endcase
   endfunction

   // Decoded fields and strobes
   wire [1:0] op_mode_field = ctrl1_reg[6:5];
   wire [3:0] channel_select = ctrl1_reg[3:0];
   wire [2:0] time_code = ctrl2_reg[3:1];
   wire wr_c1 = req.wr && !standby && (req.addr == `ADCSQ_OFS_CTRL1);
   wire wr_c2 = req.wr && !standby && (req.addr == `ADCSQ_OFS_CTRL2);
   wire rd_upper = req.rd && (req.addr == `ADCSQ_OFS_RESU);
   wire new_mode_off = wr_c1 && (req.wdata[6:5] == `ADCSQ_MODE_OFF);
   wire mode_ok = (op_mode_field == `ADCSQ_MODE_SINGLE) ||
                  (op_mode_field == `ADCSQ_MODE_REPEAT);
   wire in_idle = (state_reg == ADCSQ_IDLE);
   wire in_conv = (state_reg == ADCSQ_CONV);
   // Start taken from a stored start bit; reserved channel blocks it
   wire start_go = in_idle && ctrl1_reg[`ADCSQ_BIT_START] && mode_ok &&
                   !channel_select[3] && !standby && !new_mode_off;
   wire finish = in_conv && (cnt_reg == len_reg - 11'd1);
   wire abort = in_conv && (new_mode_off || standby);
   wire complete = finish && !abort;
   wire restart = complete && (op_mode_field == `ADCSQ_MODE_REPEAT);

   // Read mux; control two's top bits read zero as their undefined value
   wire [7:0] rd_mux =
      (req.addr == `ADCSQ_OFS_CTRL1) ? ctrl1_reg :
      (req.addr == `ADCSQ_OFS_CTRL2) ? {2'h0, ctrl2_reg[5:0]} :
      (req.addr == `ADCSQ_OFS_RESU) ? res_upper_reg :
      (req.addr == `ADCSQ_OFS_STAT) ?
         {res_low_reg, conv_end_flag_reg, conv_busy_flag_reg, 4'h0} :
      8'h00;

   // Control register one; start bit drops when the conversion begins
   always_ff @(posedge ref_clk) begin
      if (!resetn || standby) begin
         ctrl1_reg <= `ADCSQ_RST_CTRL1;
      end else if (wr_c1) begin
         ctrl1_reg <= req.wdata;
      end else if (start_go) begin
         ctrl1_reg[`ADCSQ_BIT_START] <= 1'b0;
      end
   end

   // Control register two
   always_ff @(posedge ref_clk) begin
      if (!resetn || standby) begin
         ctrl2_reg <= `ADCSQ_RST_CTRL2;
      end else if (wr_c2) begin
         ctrl2_reg <= req.wdata;
      end
   end

   // Sequencer state and cycle counter; no restart after standby
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= ADCSQ_IDLE;
         cnt_reg <= 11'd0;
         len_reg <= 11'd1;
      end else if (abort) begin
         state_reg <= ADCSQ_IDLE;
         cnt_reg <= 11'd0;
      end else if (start_go || restart) begin
         state_reg <= ADCSQ_CONV;
         cnt_reg <= 11'd0;
         len_reg <= conv_len(time_code);
      end else if (complete) begin
         state_reg <= ADCSQ_IDLE;
         cnt_reg <= 11'd0;
      end else if (in_conv) begin
         cnt_reg <= cnt_reg + 11'd1;
      end
   end

   // Busy flag follows the running conversion
   always_ff @(posedge ref_clk) begin
      if (!resetn || standby) begin
         conv_busy_flag_reg <= 1'b0;
      end else if (start_go || restart) begin
         conv_busy_flag_reg <= 1'b1;
      end else if (complete || abort) begin
         conv_busy_flag_reg <= 1'b0;
      end
   end

   // End flag: completion wins over a same-cycle clearing read
   always_ff @(posedge ref_clk) begin
      if (!resetn || standby) begin
         conv_end_flag_reg <= 1'b0;
      end else if (complete) begin
         conv_end_flag_reg <= 1'b1;
      end else if (start_go || rd_upper) begin
         conv_end_flag_reg <= 1'b0;
      end
   end

   // Result store: only on a clean completion, cleared by standby, old value kept otherwise
   always_ff @(posedge ref_clk) begin
      if (!resetn || standby) begin
         res_upper_reg <= 8'h00;
         res_low_reg <= 2'h0;
      end else if (complete) begin
         res_upper_reg <= afe_code[9:2];
         res_low_reg <= afe_code[1:0];
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
         sample_reg <= 1'b0;
      end else begin
         rdata_reg <= req.rd ? rd_mux : 8'h00;
         irq_reg <= complete;
         sample_reg <= start_go || restart;
      end
   end

   // Front-end drives; channel and gate come straight from storage
   assign rdata = rdata_reg;
   assign conv_done_irq = irq_reg;
   assign afe_sample = sample_reg;
   assign afe_channel = ctrl1_reg[2:0];
   assign afe_gate_off = ctrl1_reg[`ADCSQ_BIT_GATE];
   assign ladder_connect = ctrl2_reg[5];

   // Completion brings flag and interrupt together, and busy drop unless mode 11 restarts
   a_done_together: assert property (@(posedge ref_clk) disable iff (!resetn)
      complete |=> conv_end_flag_reg && irq_reg &&
      conv_busy_flag_reg == $past(restart))
      else $error("completion effects not together");
   a_start_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
      start_go && !wr_c1 |=> !ctrl1_reg[`ADCSQ_BIT_START])
      else $error("start bit stayed set");
   a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
      abort && !standby |=> $stable(res_upper_reg) && !conv_busy_flag_reg)
      else $error("abort stored a result");
   a_repeat_again: assert property (@(posedge ref_clk) disable iff (!resetn)
      restart |=> in_conv && conv_busy_flag_reg)
      else $error("repeat did not restart");
   a_busy_start: assert property (@(posedge ref_clk) disable iff (!resetn)
      start_go |=> conv_busy_flag_reg && !conv_end_flag_reg)
      else $error("busy not set on start");
   a_read_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
      rd_upper && !complete |=> !conv_end_flag_reg)
      else $error("end flag not cleared by read");
   a_standby_init: assert property (@(posedge ref_clk) disable iff (!resetn)
      standby |=> ctrl1_reg == `ADCSQ_RST_CTRL1 && !conv_busy_flag_reg)
      else $error("standby did not initialise");
   // Only an abort may end a run before the shortest length is counted
   a_len_min: assert property (@(posedge ref_clk) disable iff (!resetn)
      in_conv && cnt_reg < (`ADCSQ_CYC_000 - 11'd1) && !abort |=> in_conv)
      else $error("short conversion ended early");
   a_result_load: assert property (@(posedge ref_clk) disable iff (!resetn)
      complete |=> res_upper_reg == $past(afe_code[9:2]))
      else $error("result not loaded");

   // A conversion has three steps: a begin edge, a counted run and a
   // completion edge. The sequences name the first two so that the checks
   // below read as steps rather than as raw register terms.
   sequence s_conv_begin;
      start_go || restart;
   endsequence

   sequence s_conv_running;
      in_conv && conv_busy_flag_reg;
   endsequence

   // Every begin edge leads into a running, busy conversion
   a_start_runs: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_conv_begin |=> s_conv_running)
      else $error("conversion did not begin");

   // Every begin edge pulses the sample-hold once
   a_sample_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_conv_begin |=> afe_sample)
      else $error("sample not pulsed on start");

   // A reserved channel code must never start the front end
   a_resv_chan: assert property (@(posedge ref_clk) disable iff (!resetn)
      in_idle && channel_select[3] |=> in_idle)
      else $error("reserved channel started");

   // Mode 00 and the reserved mode 10 keep the sequencer idle
   a_resv_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
      in_idle && !mode_ok |=> in_idle)
      else $error("disabled mode started");

   // The counter advances one step per cycle while a run lasts
   a_count_step: assert property (@(posedge ref_clk) disable iff (!resetn)
      in_conv && !finish && !abort |=>
      in_conv && cnt_reg == $past(cnt_reg) + 11'd1)
      else $error("counter skipped a cycle");

   // Code 010 must select the 78-cycle length
   a_len_code2: assert property (@(posedge ref_clk) disable iff (!resetn)
      start_go && time_code == 3'h2 |=> len_reg == `ADCSQ_CYC_010)
      else $error("time code 010 length wrong");

   // Code 100 must select the 312-cycle length
   a_len_code4: assert property (@(posedge ref_clk) disable iff (!resetn)
      start_go && time_code == 3'h4 |=> len_reg == `ADCSQ_CYC_100)
      else $error("time code 100 length wrong");

   // A fresh start keeps the previous result readable
   a_keep_old: assert property (@(posedge ref_clk) disable iff (!resetn)
      start_go |=> $stable(res_upper_reg) && $stable(res_low_reg))
      else $error("old result lost on restart");

   // The two low result bits land in the status byte
   a_low_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
      complete |=> res_low_reg == $past(afe_code[1:0]))
      else $error("low result bits not loaded");

   // Status reads show result bits, end, busy and a zero low nibble
   a_status_image: assert property (@(posedge ref_clk) disable iff (!resetn)
      req.rd && req.addr == `ADCSQ_OFS_STAT |=>
      rdata == {$past(res_low_reg), $past(conv_end_flag_reg),
      $past(conv_busy_flag_reg), 4'h0})
      else $error("status image wrong");

   // Control two's top bits read as zero, our chosen undefined value
   a_ctrl2_top: assert property (@(posedge ref_clk) disable iff (!resetn)
      req.rd && req.addr == `ADCSQ_OFS_CTRL2 |=> rdata[7:6] == 2'h0)
      else $error("control two top bits not zero");

   // Standby also returns control two to its initial value
   a_standby_two: assert property (@(posedge ref_clk) disable iff (!resetn)
      standby |=> ctrl2_reg == `ADCSQ_RST_CTRL2)
      else $error("standby left control two");

   // Leaving standby finds the sequencer idle with no start pending
   a_no_resume: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(standby) |-> in_idle && !ctrl1_reg[`ADCSQ_BIT_START])
      else $error("converter resumed after standby");

   // The interrupt is a single-cycle pulse; a run lasts far longer
   a_irq_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      irq_reg |=> !irq_reg)
      else $error("interrupt wider than one cycle");
endmodule // adcsq_top
`default_nettype wire

// file: sim/adcsq_afe_model.sv
// Front-end stand-in: sample-hold, ladder and comparator.
// Assumes afe_sample pulses once for each conversion start.
`timescale 1ns/10ps
`default_nettype none
module adcsq_afe_model (
   input wire logic ref_clk,
   input wire logic [2:0] afe_channel,
   input wire logic afe_gate_off,
   input wire logic afe_sample,
   output logic [9:0] afe_code
);
   logic [6:0] seq_reg = 7'h00; // Sample count, so each result differs
   initial afe_code = 10'h2aa;
   // Held sample; a closed gate leaves a dead input
   always @(posedge ref_clk) begin
      if (afe_sample) begin
         seq_reg <= seq_reg + 7'h01;
         afe_code <= afe_gate_off ? 10'h000 : {afe_channel, seq_reg};
      end
   end
endmodule // adcsq_afe_model
`default_nettype wire

// file: sim/test_adcsq_top.sv
// Bench for the sequencer control block and its front-end model.
// Assumes one clock; strobes driven after rising edges.
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_params.svh"
module test_adcsq_top import adcsq_pkg::*;;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic standby = 1'b0;
   adcsq_req_t req = '0;
   logic [7:0] rdata, rv;
   logic [9:0] afe_code;
   logic [2:0] afe_channel;
   logic afe_gate_off, afe_sample, ladder_connect, conv_done_irq;
   int errors = 0;
   int n_checks = 0;
   int seq = 0; // Front-end samples expected so far
   int cyc;
   adcsq_top adcsq_top_inst (.ref_clk(ref_clk), .resetn(resetn),
      .req(req), .rdata(rdata), .standby(standby), .afe_code(afe_code),
      .afe_channel(afe_channel), .afe_gate_off(afe_gate_off),
      .afe_sample(afe_sample), .ladder_connect(ladder_connect),
      .conv_done_irq(conv_done_irq));
   adcsq_afe_model adcsq_afe_model_inst (.ref_clk(ref_clk),
      .afe_channel(afe_channel), .afe_gate_off(afe_gate_off),
      .afe_sample(afe_sample), .afe_code(afe_code));
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic wait_irq;
      cyc = 0;
      do begin
         @(posedge ref_clk);
         #1 cyc++;
      end while (conv_done_irq !== 1'b1 && cyc < 3000);
      if (conv_done_irq !== 1'b1) begin
         errors++;
         $display("Error irq expected 1 seen 0");
         test_done();
      end
   endtask
   // No interrupt may show for 100 cycles
   task automatic quiet(string nm);
      logic seen;
      seen = 1'b0;
      repeat (100) begin
         @(posedge ref_clk);
         #1 seen |= conv_done_irq;
      end
      chk(nm, 8'h00, {7'h00, seen});
   endtask
   task automatic conv1(logic [7:0] c2, logic [2:0] ch);
      wr(`ADCSQ_OFS_CTRL2, c2);
      wr(`ADCSQ_OFS_CTRL1, {5'h14, ch});
      seq++;
      rd(`ADCSQ_OFS_CTRL1);
      chk("start bit", {5'h04, ch}, rv);
      chk("channel", {5'h00, ch}, {5'h00, afe_channel});
      rd(`ADCSQ_OFS_STAT);
      chk("busy", 8'h10, rv & 8'h30);
      wait_irq();
      @(posedge ref_clk);
      #1 chk("irq width", 8'h00, {7'h00, conv_done_irq});
   endtask
   task automatic t_reset;
      rd(`ADCSQ_OFS_CTRL1);
      chk("ctrl1 reset", 8'h10, rv);
      rd(`ADCSQ_OFS_CTRL2);
      chk("ctrl2 reset", 8'h10, rv & 8'h3f);
      rd(8'h05);
      chk("unmapped", 8'h00, rv);
      chk("gate reset", 8'h01, {7'h00, afe_gate_off});
   endtask
   task automatic t_single;
      int c0;
      logic [9:0] e;
      conv1(8'h30, 3'h3);
      c0 = cyc;
      e = {3'h3, 7'(seq - 1)};
      chk("ladder", 8'h01, {7'h00, ladder_connect});
      rd(`ADCSQ_OFS_STAT);
      chk("status", {e[1:0], 6'h20}, rv);
      rd(`ADCSQ_OFS_RESU);
      chk("upper", e[9:2], rv);
      rd(`ADCSQ_OFS_STAT);
      chk("end clear", 8'h00, rv & 8'h20);
      conv1(8'h34, 3'h5);
      chk("time step", 8'd39, 8'(cyc - c0));
   endtask
   task automatic t_restart;
      logic [9:0] o;
      o = {3'h5, 7'(seq - 1)};
      wr(`ADCSQ_OFS_CTRL1, 8'ha6);
      seq++;
      rd(`ADCSQ_OFS_STAT);
      chk("restart end", 8'h10, rv & 8'h30);
      rd(`ADCSQ_OFS_RESU);
      chk("old result", o[9:2], rv);
      wait_irq();
      o = {3'h6, 7'(seq - 1)};
      rd(`ADCSQ_OFS_RESU);
      chk("new result", o[9:2], rv);
   endtask
   task automatic t_repeat;
      logic [9:0] e;
      wr(`ADCSQ_OFS_CTRL2, 8'h30);
      wr(`ADCSQ_OFS_CTRL1, 8'he2);
      wait_irq();
      wait_irq();
      seq += 2;
      e = {3'h2, 7'(seq - 1)};
      seq++;
      rd(`ADCSQ_OFS_STAT);
      chk("repeat busy", 8'h30, rv & 8'h30);
      wr(`ADCSQ_OFS_CTRL1, 8'h12);
      quiet("abort irq");
      chk("gate off", 8'h01, {7'h00, afe_gate_off});
      rd(`ADCSQ_OFS_STAT);
      chk("abort busy", 8'h00, rv & 8'h10);
      rd(`ADCSQ_OFS_RESU);
      chk("abort result", e[9:2], rv);
   endtask
   // Reserved channel and mode codes start no conversion; the start bit is checked pending after the channel case
   task automatic t_reserved;
      wr(`ADCSQ_OFS_CTRL1, 8'ha8);
      quiet("reserved channel");
      rd(`ADCSQ_OFS_CTRL1);
      chk("pending start", 8'ha8, rv);
      wr(`ADCSQ_OFS_CTRL1, 8'hc3);
      quiet("reserved mode");
      wr(`ADCSQ_OFS_CTRL1, 8'h10);
   endtask
   task automatic t_standby;
      wr(`ADCSQ_OFS_CTRL1, 8'ha1);
      seq++;
      repeat (3) @(posedge ref_clk);
      standby <= 1'b1;
      wr(`ADCSQ_OFS_CTRL1, 8'h01);
      rd(`ADCSQ_OFS_CTRL1);
      chk("standby ctrl1", 8'h10, rv);
      rd(`ADCSQ_OFS_STAT);
      chk("standby status", 8'h00, rv);
      @(posedge ref_clk);
      standby <= 1'b0;
      quiet("no resume");
   endtask
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_single();
      t_restart();
      t_repeat();
      t_reserved();
      t_standby();
      test_done();
   end
endmodule // test_adcsq_top
`default_nettype wire
